//--- core/aiu_unit.sv
// arbitrating interrupt unit with watchdog, time-out timer and apb slave
`timescale 1ns/100ps
module aiu_unit
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire aiu_pkg::aiu_rx_t rx_in,
  input wire logic [7:0] tx_empty,
  input wire aiu_pkg::aiu_events_t events,
  input wire logic bit_tick,
  input wire logic ct_tick,
  input wire logic int_acknowledge_n,
  output logic int_request_n,
  output logic [7:0] ack_vector,
  output logic ack_valid
);
  import aiu_pkg::*;

  // =====================================================
  // registers
  logic [NSRC-1:0] source_mask_reg_r;
  logic [NSRC-1:0] status_ev_r;
  logic [11:0] interrupt_control_reg_r;
  logic [7:0] mode_reg_one_r;
  logic [7:0] mode_reg_zero_r;
  logic [7:0] watchdog_char_flow_enable_reg_r;
  logic [7:0] timer_preset_upper_r;
  logic [7:0] timer_preset_lower_r;
  logic [7:0] vector_r;
  logic [11:0] current_winner_reg_r;
  logic [6:0] prog_r [NPROG];
  logic timeout_mode_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // =====================================================
  // apb decode: one wait-free access, answered by pready_r
  wire logic access = psel & penable & pready_r;
  wire logic wr = access & pwrite;
  wire logic cmd_wr = wr & (paddr == OFS_CMD);
  wire logic [3:0] cmd = pwdata[7:4];
  wire logic to_on = cmd_wr & (cmd == CMD_TO_ON); // see (R04)
  wire logic to_off = cmd_wr & (cmd == CMD_TO_OFF); // see (R04)
  wire logic upd_win = cmd_wr & (cmd == CMD_UPD_WIN); // see (R14)
  wire logic ct_start = cmd_wr & (cmd == CMD_CT_START) & ~timeout_mode_r; // see (R08)
  wire logic ct_stop = cmd_wr & (cmd == CMD_CT_STOP) & ~timeout_mode_r; // see (R08)
  wire logic prog_hit = (paddr >= OFS_PROG0) && (paddr < OFS_PROG0 + 8'(4 * NPROG));
  wire logic [2:0] prog_idx = 3'((paddr - OFS_PROG0) >> 2);
  wire logic unmapped = (paddr[1:0] != 2'b00) | ~(prog_hit | (paddr <= OFS_WIN));

  // =====================================================
  // pin input: three flops, change counts when last two agree
  logic [2:0] ack_sync_r;
  logic ack_level_r;
  wire logic ack_edge = (ack_sync_r[2] == ack_sync_r[1]) & ~ack_sync_r[1] & ack_level_r;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ack_sync_r <= 3'h7;
      ack_level_r <= 1'b1;
    end
    else
    begin
      ack_sync_r <= {ack_sync_r[1:0], int_acknowledge_n};
      if (ack_sync_r[2] == ack_sync_r[1])
        ack_level_r <= ack_sync_r[1];
    end
  end

  // =====================================================
  // receiver watchdog: counts bit times while the fifo sits idle
  logic [5:0] wd_cnt_r;
  logic wd_done_r;
  wire logic wd_restart = rx_in.fifo_read | rx_in.char_write; // see (R02)
  wire logic wd_fire = bit_tick & ~wd_done_r & (wd_cnt_r == WD_LAST) & ~wd_restart; // see (R01)
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wd_cnt_r <= '0;
      wd_done_r <= 1'b0;
    end
    else if (wd_restart)
    begin
      wd_cnt_r <= '0;
      wd_done_r <= 1'b0;
    end
    else if (bit_tick & ~wd_done_r)
    begin
      wd_cnt_r <= wd_cnt_r + 6'h1;
      wd_done_r <= wd_fire;
    end
  end

  // =====================================================
  // counter/timer: free commands, or paced by received characters
  aiu_ct_state_t ct_state_r;
  aiu_ct_state_t ct_state_nxt;
  logic [15:0] ct_cnt_r;
  wire logic [15:0] preset = {timer_preset_upper_r, timer_preset_lower_r};
  wire logic ct_expire = (ct_state_r == AIU_CT_RUN) & ct_tick & (ct_cnt_r == 16'h0); // see (R06)
  always_comb
  begin
    ct_state_nxt = ct_state_r;
    unique case (ct_state_r)
      AIU_CT_IDLE: if (ct_start) ct_state_nxt = AIU_CT_LOAD;
      AIU_CT_HOLD: if (ct_tick) ct_state_nxt = AIU_CT_LOAD; // see (R05)
      AIU_CT_LOAD: if (ct_tick) ct_state_nxt = AIU_CT_RUN; // see (R05)
      AIU_CT_RUN: if (ct_expire | ct_stop) ct_state_nxt = AIU_CT_IDLE;
    endcase
    // a character restarts the timer only in time-out mode
    if (timeout_mode_r & rx_in.char_write)
      ct_state_nxt = AIU_CT_HOLD; // see (R05) (R08)
    if (to_on)
      ct_state_nxt = AIU_CT_IDLE; // see (R07)
  end

  // count down; the reload happens on a start command or on the tick that ends the hold
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ct_state_r <= AIU_CT_IDLE;
      ct_cnt_r <= '0;
    end
    else
    begin
      ct_state_r <= ct_state_nxt;
      if ((ct_state_nxt == AIU_CT_LOAD) & (ct_state_r != AIU_CT_LOAD))
        ct_cnt_r <= preset;
      else if ((ct_state_r == AIU_CT_RUN) & ct_tick & (ct_cnt_r != 16'h0))
        ct_cnt_r <= ct_cnt_r - 16'h1;
    end
  end

  // =====================================================
  // status: fifo bits are levels, the others sticky events
  wire logic [1:0] rx_sel = mode_reg_zero_r[1:0];
  wire logic [1:0] tx_sel = mode_reg_zero_r[3:2];
  wire logic rx_bid_level = rx_in.fill >= LVL_START[8*rx_sel +: 8]; // see (R18)
  wire logic tx_bid_level = tx_empty >= LVL_START[8*tx_sel +: 8]; // see (R18)
  wire logic [NSRC-1:0] ev_set = {events, ct_expire, wd_fire, 2'b00};
  wire logic [NSRC-1:0] ev_clr = (wr & (paddr == OFS_STAT)) ? pwdata[NSRC-1:0] : '0;
  wire logic [NSRC-1:0] status = {status_ev_r[NSRC-1:2], tx_bid_level, rx_bid_level};
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      status_ev_r <= '0;
    else
    begin
      // set wins over a clear in the same cycle
      status_ev_r <= (status_ev_r & ~ev_clr) | ev_set;
      if ((to_on | to_off) & ~ct_expire)
        status_ev_r[SRC_CT] <= 1'b0; // see (R07) (R09)
      if (wd_restart & ~wd_fire)
        status_ev_r[SRC_WD] <= 1'b0;
    end
  end

  // =====================================================
  // bids and enables, one entry per source
  logic [11:0] bid [NSRC];
  logic [11:0] best [NSRC+1];
  logic [NSRC-1:0] act;
  assign bid[SRC_RX] = {rx_in.fill, rx_in.char_error ? TY_RX_ERR : TY_RX, CHAN}; // see (R11)
  assign bid[SRC_TX] = {tx_empty, TY_TX, CHAN}; // see (R11)
  assign bid[SRC_WD] = {rx_in.fill, TY_WD, CHAN}; // see (R11)
  assign best[0] = 12'h000; // see (R21)
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++)
    begin : g_src
      if (gi >= SRC_CT)
      begin : g_prog
        assign bid[gi] = {prog_r[gi-SRC_CT], TY_PROG[4*(gi-SRC_CT) +: 4], CHAN}; // see (R12) (R20)
      end
      if (gi == SRC_WD)
      begin : g_wd
        assign act[gi] = status[gi] & watchdog_char_flow_enable_reg_r[0]; // see (R03)
      end
      else
      begin : g_mask
        assign act[gi] = status[gi] & source_mask_reg_r[gi]; // see (R16)
      end
      // running maximum over enabled bids
      assign best[gi+1] = (act[gi] && bid[gi] > best[gi]) ? bid[gi] : best[gi]; // see (R10)
    end
  endgenerate

  // =====================================================
  // half-rate arbitration: sample on phase 0, publish on phase 1
  logic phase_r;
  logic [11:0] snap_r;
  logic [11:0] cand_r;
  wire logic over = cand_r[11:1] > interrupt_control_reg_r[10:0]; // see (R19)
  wire logic capture = ack_edge | upd_win;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      phase_r <= 1'b0;
      snap_r <= '0;
      cand_r <= '0;
    end
    else
    begin
      phase_r <= ~phase_r;
      if (!phase_r)
        snap_r <= best[NSRC]; // see (R24)
      else
        cand_r <= snap_r; // see (R24)
    end
  end

  // =====================================================
  // winner capture, vector answer and request pin
  wire logic [11:0] win_nxt = over ? cand_r : 12'h000; // see (R23) (R22)
  wire logic [7:0] vec_mod = {vector_r[7:4], win_nxt[4:1]}; // see (R20)
  wire logic vmod = interrupt_control_reg_r[ICR_VMOD_BIT];
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      current_winner_reg_r <= '0;
      ack_vector <= '0;
      ack_valid <= 1'b0;
      int_request_n <= 1'b1;
    end
    else
    begin
      if (capture)
        current_winner_reg_r <= win_nxt; // see (R13) (R25)
      ack_valid <= ack_edge; // see (R15)
      if (ack_edge)
        ack_vector <= vmod ? vec_mod : vector_r; // see (R15)
      int_request_n <= ~over; // see (R26)
    end
  end

  // =====================================================
  // software registers and mode
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      source_mask_reg_r <= '0;
      interrupt_control_reg_r <= ICR_RST;
      mode_reg_one_r <= '0;
      mode_reg_zero_r <= '0;
      watchdog_char_flow_enable_reg_r <= '0;
      timer_preset_upper_r <= '0;
      timer_preset_lower_r <= '0;
      vector_r <= VEC_RST;
      timeout_mode_r <= 1'b0;
      for (int i = 0; i < NPROG; i++)
        prog_r[i] <= PROG_RST[6:0];
    end
    else
    begin
      if (to_on)
        timeout_mode_r <= 1'b1; // see (R04)
      else if (to_off)
        timeout_mode_r <= 1'b0; // see (R04)
      if (wr)
      begin
        unique case (paddr)
          OFS_MASK: source_mask_reg_r <= pwdata[NSRC-1:0];
          OFS_ICR: interrupt_control_reg_r <= pwdata[11:0];
          OFS_MR1: mode_reg_one_r <= pwdata[7:0];
          OFS_MR0: mode_reg_zero_r <= pwdata[7:0];
          OFS_WCX: watchdog_char_flow_enable_reg_r <= pwdata[7:0];
          OFS_TIMER_PRESET_UPPER: timer_preset_upper_r <= pwdata[7:0];
          OFS_TIMER_PRESET_LOWER: timer_preset_lower_r <= pwdata[7:0];
          OFS_VEC: vector_r <= pwdata[7:0];
          default:
            if (prog_hit)
              prog_r[prog_idx] <= pwdata[6:0];
        endcase
      end
    end
  end

  // =====================================================
  // read mux; status may be masked on read
  wire logic masked_rd = mode_reg_one_r[MR1_MASKED_BIT];
  wire logic [NSRC-1:0] stat_rd = masked_rd ? (status & source_mask_reg_r) : status; // see (R17)
  logic [31:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 32'h0;
    unique case (paddr)
      OFS_MASK: rd_nxt = {23'h0, source_mask_reg_r};
      OFS_STAT: rd_nxt = {23'h0, stat_rd};
      OFS_ICR: rd_nxt = {20'h0, interrupt_control_reg_r};
      OFS_MR1: rd_nxt = {24'h0, mode_reg_one_r};
      OFS_MR0: rd_nxt = {24'h0, mode_reg_zero_r};
      OFS_WCX: rd_nxt = {24'h0, watchdog_char_flow_enable_reg_r};
      OFS_TIMER_PRESET_UPPER: rd_nxt = {24'h0, timer_preset_upper_r};
      OFS_TIMER_PRESET_LOWER: rd_nxt = {24'h0, timer_preset_lower_r};
      OFS_VEC: rd_nxt = {24'h0, vector_r};
      OFS_WIN: rd_nxt = {20'h0, current_winner_reg_r};
      default: rd_nxt = prog_hit ? {25'h0, prog_r[prog_idx]} : 32'h0;
    endcase
  end

  // answer in the cycle after setup
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel & ~penable & ~pready_r;
      pslverr_r <= psel & ~penable & unmapped;
      if (psel & ~penable & ~pwrite)
        prdata_r <= unmapped ? 32'h0 : rd_nxt;
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // =====================================================
  // checks
  a_wd_fire_count: assert property (@(posedge clock) disable iff (!reset_n)
    wd_fire |-> wd_cnt_r == 6'h3f && !wd_done_r) else $error("watchdog early"); // see (R01)
  a_wd_restart: assert property (@(posedge clock) disable iff (!reset_n)
    wd_restart |=> wd_cnt_r == 6'h0 && !status_ev_r[SRC_WD]) else $error("no wd restart"); // see (R02)
  a_to_on_stops: assert property (@(posedge clock) disable iff (!reset_n)
    to_on && !ct_expire |=> ct_state_r == AIU_CT_IDLE && !status_ev_r[SRC_CT]
      && timeout_mode_r) else $error("time-out on wrong"); // see (R07) (R04)
  a_to_off_clears: assert property (@(posedge clock) disable iff (!reset_n)
    to_off && !ct_expire |=> !status_ev_r[SRC_CT] && !timeout_mode_r)
    else $error("time-out off wrong"); // see (R09)
  a_char_reload: assert property (@(posedge clock) disable iff (!reset_n)
    timeout_mode_r && ct_state_r == AIU_CT_HOLD && ct_tick && !rx_in.char_write && !to_on
      |=> ct_state_r == AIU_CT_LOAD && ct_cnt_r == $past(preset))
    else $error("reload missed"); // see (R05)
  a_start_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    timeout_mode_r |-> !ct_start && !ct_stop) else $error("start honoured"); // see (R08)
  a_expire_sets: assert property (@(posedge clock) disable iff (!reset_n)
    ct_expire |=> status_ev_r[SRC_CT]) else $error("ready not set"); // see (R06)
  a_mask_gate: assert property (@(posedge clock) disable iff (!reset_n)
    (act & ~source_mask_reg_r & ~(9'h1 << SRC_WD)) == '0) else $error("unmasked bid"); // see (R16)
  a_cand_rate: assert property (@(posedge clock) disable iff (!reset_n)
    !phase_r |=> $stable(cand_r)) else $error("candidate off phase"); // see (R24)
  a_cand_pipe: assert property (@(posedge clock) disable iff (!reset_n)
    !phase_r ##1 1 |=> cand_r == $past(best[NSRC], 2)) else $error("bad candidate"); // see (R10)
  a_capture_val: assert property (@(posedge clock) disable iff (!reset_n)
    capture |=> current_winner_reg_r == ($past(over) ? $past(cand_r) : 12'h000))
    else $error("wrong winner"); // see (R13) (R23)
  a_winner_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !capture |=> $stable(current_winner_reg_r)) else $error("winner moved"); // see (R25)
  a_irq_follow: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 int_request_n == !$past(cand_r[11:1] > interrupt_control_reg_r[10:0]))
    else $error("request wrong"); // see (R26) (R19)
  c_ack_win: cover property (@(posedge clock) disable iff (!reset_n) ack_edge && over);
  c_upd_zero: cover property (@(posedge clock) disable iff (!reset_n) upd_win && !over);
  c_ct_timeout: cover property (@(posedge clock) disable iff (!reset_n)
    timeout_mode_r && ct_expire);
  c_wd_fire: cover property (@(posedge clock) disable iff (!reset_n) wd_fire);
endmodule

//--- core/aiu_pkg.sv
// constants, types and register map of the arbitrating interrupt unit
// =====================================================================
// How it works
// (R01) watchdog flags time-out after 64 idle bit times
// (R02) fifo read or receiver write restarts watchdog
// (R03) only watchdog enable bits gate watchdog interrupt
// (R04) command Ax enters, Cx leaves time-out mode
// (R05) in time-out mode each character stops, reloads, restarts timer per tick
// (R06) timer expiry sets ready bit three, masked bids
// (R07) time-out-on command clears ready, holds timer stopped
// (R08) time-out mode ignores start/stop, counts per character
// (R09) time-out-off command clears the ready bit
// (R10) arbiter always offers highest enabled bid
// (R11) fifo bid is level, type code, channel
// (R12) fifo-less sources bid with programmable field
// (R13) acknowledge latches current highest bid into winner
// (R14) host without acknowledge updates then reads winner
// (R15) acknowledge refreshes winner and returns its vector
// (R16) masked-off source other than watchdog never bids, requests or wins
// (R17) status read returns all, optionally ANDed with mask
// (R18) fifo bidding starts at a selectable fill level
// (R19) bid above threshold, threshold bit0 at bid bit1
// (R20) bid bits 3:1 (fifo) or 4:1 (programmed) carry a unique type code
// (R21) eleven source kinds including none
// (R22) winner value zero means no interrupt active
// (R23) capture with nothing above threshold loads zero
// (R24) arbitration yields a candidate every two cycles
// (R25) winner holds until next acknowledge or update
// (R26) request pin low while a bid beats threshold
package aiu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_ICR = 8'h0c;
  localparam logic [7:0] OFS_MR1 = 8'h10;
  localparam logic [7:0] OFS_MR0 = 8'h14;
  localparam logic [7:0] OFS_WCX = 8'h18;
  localparam logic [7:0] OFS_TIMER_PRESET_UPPER = 8'h1c;
  localparam logic [7:0] OFS_TIMER_PRESET_LOWER = 8'h20;
  localparam logic [7:0] OFS_VEC = 8'h24;
  localparam logic [7:0] OFS_WIN = 8'h28;
  localparam logic [7:0] OFS_PROG0 = 8'h30;
  // command codes, upper nibble of the command byte
  localparam logic [3:0] CMD_CT_START = 4'h8;
  localparam logic [3:0] CMD_CT_STOP = 4'h9;
  localparam logic [3:0] CMD_TO_ON = 4'ha;
  localparam logic [3:0] CMD_UPD_WIN = 4'hb;
  localparam logic [3:0] CMD_TO_OFF = 4'hc;
  // source / status bit positions; fifo-less sources are 3..8
  localparam int NSRC = 9;
  localparam int SRC_RX = 0;
  localparam int SRC_TX = 1;
  localparam int SRC_WD = 2;
  localparam int SRC_CT = 3;
  localparam int NPROG = 6;
  localparam int MR1_MASKED_BIT = 6;
  localparam int ICR_VMOD_BIT = 11;
  // type codes in bid bits 3:1 (fifo) or 4:1 (programmed), ct..addr
  localparam logic [2:0] TY_RX = 3'h1;
  localparam logic [2:0] TY_RX_ERR = 3'h5;
  localparam logic [2:0] TY_WD = 3'h4;
  localparam logic [2:0] TY_TX = 3'h2;
  // nibbles from low: ct 1000, break 1110, loop 1111, cos 0110, xon 0111, addr 1011
  localparam logic [23:0] TY_PROG = 24'hb76fe8;
  localparam logic CHAN = 1'b0;
  // bid start levels: not empty, 50, 75, 100 percent
  localparam logic [31:0] LVL_START = 32'hffc08001;
  // counts and reset values
  localparam logic [5:0] WD_LAST = 6'h3f; // 64 bit times
  localparam logic [11:0] ICR_RST = 12'h7ff;
  localparam logic [7:0] VEC_RST = 8'h0f;
  localparam logic [7:0] PROG_RST = 8'h00;
  typedef enum logic [1:0] {
    AIU_CT_IDLE = 2'b00,
    AIU_CT_HOLD = 2'b01,
    AIU_CT_LOAD = 2'b10,
    AIU_CT_RUN = 2'b11
  } aiu_ct_state_t;
  // single-cycle events from the channel logic
  typedef struct packed {
    logic addr_match;
    logic flow_char;
    logic pin_change;
    logic loop_error;
    logic break_change;
  } aiu_events_t;
  // receive side handshake from the channel logic
  typedef struct packed {
    logic char_write;
    logic fifo_read;
    logic char_error;
    logic [7:0] fill;
  } aiu_rx_t;
endpackage

//--- tb/aiu_host.sv
// host cpu model: apb master and acknowledge pin driver
`timescale 1ns/100ps
module aiu_host
(
  input wire logic clock,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic int_acknowledge_n
);
  // ====================================================
  // idle levels at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_acknowledge_n = 1'b1;
  end

  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 32);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 32)
      tb_arbitrating_interrupt_unit.hang();
  endtask

  // acknowledge held long enough to pass the pin filter, then released
  task automatic ack();
    @(posedge clock);
    int_acknowledge_n <= 1'b0;
    repeat (8) @(posedge clock);
    int_acknowledge_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule

//--- tb/tb_arbitrating_interrupt_unit.sv
// self-checking bench for the arbitrating interrupt unit
`timescale 1ns/100ps
module tb_arbitrating_interrupt_unit;
  import aiu_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ack_valid, int_request_n, iack_n;
  logic bit_tick = 1'b0;
  logic ct_tick = 1'b0;
  logic [7:0] paddr, ack_vector, fill, fill2;
  logic [7:0] tx_empty = 8'h00;
  logic [31:0] pwdata, prdata, seed;
  logic [10:0] bidv;
  logic [31:0] exp_q[$];
  aiu_rx_t rx_in = '0;
  aiu_events_t ev = '0;
  int err_count = 0;
  int checks = 0;
  const logic [7:0] lvl_min[4] = '{8'h01, 8'h80, 8'hc0, 8'hff};

  always #4 clock = ~clock;

  aiu_host host (.clock(clock), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .int_acknowledge_n(iack_n));
  aiu_unit dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .tx_empty(tx_empty), .events(ev),
    .bit_tick(bit_tick), .ct_tick(ct_tick), .int_acknowledge_n(iack_n),
    .int_request_n(int_request_n), .ack_vector(ack_vector), .ack_valid(ack_valid));

  // ====================================================
  // comparison and closing
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    check("pending", exp_q.size(), 0);
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    end_sim();
  endtask

  // monitor: read data and acknowledge vectors take the oldest note
  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite)
      check("read", prdata, exp_q.size() ? exp_q.pop_front() : ~prdata);
    if (ack_valid === 1'b1)
      check("vector", ack_vector, exp_q.size() ? exp_q.pop_front() : ~ack_vector);
  end

  // ====================================================
  // stimulus helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(a, 32'h0, 1'b0);
  endtask

  // request settles 3..4 cycles after a bid change; 6 gives margin
  task automatic irq_is(input logic e);
    repeat (6) @(posedge clock);
    #1;
    check("irq", int_request_n, e);
  endtask

  task automatic ticks(input int n, input logic ct);
    repeat (n)
    begin
      @(posedge clock);
      if (ct) ct_tick <= 1'b1;
      else bit_tick <= 1'b1;
      @(posedge clock);
      ct_tick <= 1'b0;
      bit_tick <= 1'b0;
    end
  endtask

  task automatic rx_pulse(input logic w);
    @(posedge clock);
    rx_in.char_write <= w;
    rx_in.fifo_read <= ~w;
    @(posedge clock);
    rx_in.char_write <= 1'b0;
    rx_in.fifo_read <= 1'b0;
  endtask

  // hang guard
  initial
  begin
    #600000;
    hang();
  end

  // ====================================================
  // main sequence
  initial
  begin
    seed = $urandom(32'hfd18b1dc);
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rd(OFS_ICR, 32'h7ff);
    rd(OFS_VEC, 32'h0f);
    rd(OFS_WIN, 32'h0);
    rd(8'h2c, 32'h0);
    tx_empty <= 8'($urandom_range(255));
    $display("test reset done");
    // start levels of receiver bidding
    wr(OFS_MASK, 32'h1);
    wr(OFS_ICR, 32'h0);
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(OFS_MR0, lv);
      rx_in.fill <= lvl_min[lv];
      irq_is(1'b0);
      rx_in.fill <= lvl_min[lv] - 8'h01;
      irq_is(1'b1);
    end
    $display("test levels done");
    // threshold, update, hold and acknowledge
    wr(OFS_MR0, 32'h0);
    fill = 8'($urandom_range(127, 1));
    fill2 = fill + 8'h80;
    bidv = {fill, TY_RX};
    rx_in.fill <= fill;
    wr(OFS_ICR, 32'(bidv));
    irq_is(1'b1);
    wr(OFS_ICR, 32'(bidv - 11'h1));
    irq_is(1'b0);
    wr(OFS_CMD, 32'hb0);
    rd(OFS_WIN, {20'h0, bidv, 1'b0});
    rx_in.fill <= fill2;
    repeat (6) @(posedge clock);
    rd(OFS_WIN, {20'h0, bidv, 1'b0});
    wr(OFS_ICR, 32'h800);
    exp_q.push_back({24'h0, 4'h0, fill2[0], TY_RX});
    host.ack();
    rd(OFS_WIN, {20'h0, fill2, TY_RX, 1'b0});
    wr(OFS_MASK, 32'h0);
    irq_is(1'b1);
    wr(OFS_CMD, 32'hb0);
    rd(OFS_WIN, 32'h0);
    $display("test arbitration done");
    // time-out mode of the counter/timer, masked status reads
    wr(OFS_MR1, 32'h40);
    wr(OFS_MASK, 32'h8);
    wr(OFS_TIMER_PRESET_UPPER, 32'h0);
    wr(OFS_TIMER_PRESET_LOWER, 32'h3);
    wr(OFS_CMD, 32'ha0);
    wr(OFS_CMD, 32'h80);
    ticks(12, 1'b1);
    rd(OFS_STAT, 32'h0);
    rx_pulse(1'b1);
    ticks(12, 1'b1);
    rd(OFS_STAT, 32'h8);
    irq_is(1'b0);
    wr(OFS_CMD, 32'hc0);
    rd(OFS_STAT, 32'h0);
    $display("test timeout done");
    // receiver watchdog
    wr(OFS_MASK, 32'h4);
    wr(OFS_WCX, 32'h1);
    rx_pulse(1'b0);
    ticks(62, 1'b0);
    rd(OFS_STAT, 32'h0);
    ticks(4, 1'b0);
    rd(OFS_STAT, 32'h4);
    rx_pulse(1'b0);
    rd(OFS_STAT, 32'h0);
    $display("test watchdog done");
    // programmed break source bids with its own type code
    wr(OFS_PROG0 + 8'h04, 32'h7f);
    wr(OFS_MASK, 32'h10);
    @(posedge clock);
    ev.break_change <= 1'b1;
    @(posedge clock);
    ev.break_change <= 1'b0;
    irq_is(1'b0);
    rd(OFS_STAT, 32'h10);
    wr(OFS_CMD, 32'hb0);
    rd(OFS_WIN, 32'hffc);
    wr(OFS_STAT, 32'h10);
    rd(OFS_STAT, 32'h0);
    $display("test events done");
    repeat (4) @(posedge clock);
    end_sim();
  end
endmodule
